// ### design/srt_defs.svh
// Purpose: Constants for the SYSREF, test mode and link error register bank
// Assumes: APB byte addresses, 32-bit data
// Notes:   Offsets are the printed byte offsets
//
// Function
// - TX resync with SYSREF required: send K28.5
// - RX resync with SYSREF required: hold SYNC
// - TX resync, no SYSREF: ILA at next boundary
// - RX resync, no SYSREF: release SYNC at boundary
// - SYSREF delay field postpones realignment 0-15 cycles
// - SYSREF-always set: realign on every event
// - SYSREF-always clear: align on first event only
// - ILA multiframe count minus one, reset three
// - Test codes 0-3: normal, K28.5, ILA, D21.5
// - TX only: code five RPAT, seven JSPAT
// - Test bit four: PRBS, link data off (TX only)
// - Seven misaligned alignment characters set alarm
// - Subclass 1 misaligned SYSREF sets alarm
// - Lane buffer overflow sets alarm
// - Eight 3-bit lane fields, bits 28:24 zero
// - Lane field: K-char, disparity, not-in-table
// - Error bits sticky, cleared on read
// - Errors recorded only after lane sync
// - Reset or watchdog clears error word
`ifndef SRT_DEFS_SVH
`define SRT_DEFS_SVH

`define SRT_OFS_SYSREF      12'h010
`define SRT_OFS_ILA_LEN     12'h014
`define SRT_OFS_TEST        12'h018
`define SRT_OFS_ERR         12'h01C

`define SRT_BIT_ALWAYS      0
`define SRT_BIT_RESYNC_REQ  16
`define SRT_DLY_LSB         8
`define SRT_DLY_MSB         11
`define SRT_BIT_PRBS        4
`define SRT_BIT_ALIGN_ALARM 31
`define SRT_BIT_SYSREF_ALRM 30
`define SRT_BIT_OVF_ALARM   29

`define SRT_RST_SYSREF      32'h0000_00FE
`define SRT_RST_ILA_LEN     8'h03
`define SRT_RST_TEST        5'h00
`define SRT_SYSREF_MASK     32'h0001_0F01
`define SRT_RSVD_ONES       32'h0000_00FE

`define SRT_MISALIGN_LIMIT  3'h7
`define SRT_LANES           8

`endif

// ### design/srt_pkg.sv
// Purpose: Types for the SYSREF, test mode and link error register bank
// Assumes: Used with srt_defs.svh
// Notes:   Nothing here is imported
package srt_pkg;

	typedef enum logic [4:0] {
		SRT_TM_NORMAL = 5'h00,
		SRT_TM_K285   = 5'h01,
		SRT_TM_ILA    = 5'h02,
		SRT_TM_D215   = 5'h03,
		SRT_TM_RPAT   = 5'h05,
		SRT_TM_JSPAT  = 5'h07
	} srt_test_e;

	typedef enum logic [3:0] {
		SRT_LS_RUN   = 4'b0001,
		SRT_LS_WSYS  = 4'b0010,
		SRT_LS_WLMFC = 4'b0100,
		SRT_LS_ALIGN = 4'b1000
	} srt_link_e;

endpackage

// ### design/srt_regs.sv
// Purpose: SYSREF alignment, ILA length, test mode and link error registers
// Assumes: One clock pclk at 250 MHz, async active-low presetn, APB slave
// Notes:   Core events come in as single-cycle pulses on pclk
`include "srt_defs.svh"
`timescale 1ns/1ps

module srt_regs (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Core configuration
	input  wire logic        is_tx,
	input  wire logic        subclass1,
	// SYSREF pin
	input  wire logic        sysref_in,
	// Link events
	input  wire logic        resync_req,
	input  wire logic        lmfc_boundary,
	input  wire logic        lane_sync_done,
	input  wire logic        watchdog_clear,
	input  wire logic [7:0]  lane_misalign,
	input  wire logic [7:0]  lane_align_ok,
	input  wire logic        buffer_overflow,
	input  wire logic [7:0]  err_kchar,
	input  wire logic [7:0]  err_disp,
	input  wire logic [7:0]  err_nit,
	// Link control outputs
	output logic             lmfc_realign,
	output logic             send_k285,
	output logic             start_ila,
	output logic             sync_hold,
	output logic       [7:0] alignment_sequence_length,
	output logic       [4:0] test_select,
	output logic             prbs_enable,
	output logic             link_data_off
);

	// Checks below share this clock and reset
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [31:0] sysref_ctl_ff;
	logic [7:0]  ila_len_ff;
	logic [4:0]  test_sel_ff;
	logic [31:0] err_ff;
	logic [31:0] nxt_err;
	logic        rd_err;
	logic        wr_en;
	logic        rd_en;
	logic [31:0] rdata;
	logic        addr_ok;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign rd_err = rd_en && (paddr == `SRT_OFS_ERR);

	always_comb begin
		addr_ok = 1'b1;
		rdata   = 32'h0000_0000;
		case (paddr)
			`SRT_OFS_SYSREF:  rdata = sysref_ctl_ff;
			`SRT_OFS_ILA_LEN: rdata = {24'h00_0000, ila_len_ff};
			`SRT_OFS_TEST:    rdata = {27'h000_0000, test_sel_ff};
			`SRT_OFS_ERR:     rdata = err_ff;
			default:          addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			if (psel && !penable && !pwrite && addr_ok)
				prdata <= rdata;
		end
	end

	// Writes and reads take effect in the access cycle (pready high)
	logic acc;
	assign acc = pready && psel && penable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sysref_ctl_ff <= `SRT_RST_SYSREF;
			ila_len_ff    <= `SRT_RST_ILA_LEN;
			test_sel_ff   <= `SRT_RST_TEST;
		end else if (acc && pwrite) begin
			case (paddr)
				`SRT_OFS_SYSREF:
					sysref_ctl_ff <= (pwdata & `SRT_SYSREF_MASK)
						| `SRT_RSVD_ONES;
				`SRT_OFS_ILA_LEN: ila_len_ff  <= pwdata[7:0];
				`SRT_OFS_TEST:    test_sel_ff <= pwdata[4:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// SYSREF detection and delayed realignment

	logic       sys_s1_ff;
	logic       sys_s2_ff;
	logic       sys_s3_ff;
	logic       sys_evt;
	logic       seen_first_ff;
	logic       sys_take;
	logic [3:0] dly_ff;
	logic       dly_run_ff;
	logic       realign_ff;
	logic       dly_zero;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_s1_ff <= 1'b0;
			sys_s2_ff <= 1'b0;
			sys_s3_ff <= 1'b0;
		end else begin
			sys_s1_ff <= sysref_in;
			sys_s2_ff <= sys_s1_ff;
			sys_s3_ff <= sys_s2_ff;
		end
	end

	assign sys_evt = sys_s2_ff && !sys_s3_ff;
	assign sys_take = sys_evt && (sysref_ctl_ff[`SRT_BIT_ALWAYS]
		|| !seen_first_ff);
	assign dly_zero = (sysref_ctl_ff[`SRT_DLY_MSB:`SRT_DLY_LSB] == 4'h0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			seen_first_ff <= 1'b0;
		else if (sys_evt)
			seen_first_ff <= 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_ff     <= 4'h0;
			dly_run_ff <= 1'b0;
			realign_ff <= 1'b0;
		end else begin
			realign_ff <= 1'b0;
			if (sys_take && dly_zero) begin
				realign_ff <= 1'b1;
				dly_run_ff <= 1'b0;
			end else if (sys_take) begin
				dly_ff     <= sysref_ctl_ff[`SRT_DLY_MSB:`SRT_DLY_LSB] - 4'h1;
				dly_run_ff <= 1'b1;
			end else if (dly_run_ff) begin
				if (dly_ff == 4'h0) begin
					realign_ff <= 1'b1;
					dly_run_ff <= 1'b0;
				end else
					dly_ff <= dly_ff - 4'h1;
			end
		end
	end

	assign lmfc_realign = realign_ff;

	////////////////////////////////////////////////////////////////////////
	// Re-synchronisation sequencing

	srt_pkg::srt_link_e state_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_ff <= srt_pkg::SRT_LS_RUN;
		else begin
			case (state_ff)
				srt_pkg::SRT_LS_RUN:
					if (resync_req)
						state_ff <= sysref_ctl_ff[`SRT_BIT_RESYNC_REQ]
							? srt_pkg::SRT_LS_WSYS
							: srt_pkg::SRT_LS_WLMFC;
				srt_pkg::SRT_LS_WSYS:
					if (realign_ff)
						state_ff <= srt_pkg::SRT_LS_WLMFC;
				srt_pkg::SRT_LS_WLMFC:
					if (lmfc_boundary)
						state_ff <= srt_pkg::SRT_LS_ALIGN;
				srt_pkg::SRT_LS_ALIGN:
					state_ff <= srt_pkg::SRT_LS_RUN;
				default:
					state_ff <= srt_pkg::SRT_LS_RUN;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			send_k285 <= 1'b0;
			sync_hold <= 1'b0;
			start_ila <= 1'b0;
		end else begin
			send_k285 <= is_tx && (state_ff == srt_pkg::SRT_LS_WSYS
				|| state_ff == srt_pkg::SRT_LS_WLMFC);
			sync_hold <= !is_tx && (state_ff == srt_pkg::SRT_LS_WSYS
				|| state_ff == srt_pkg::SRT_LS_WLMFC);
			start_ila <= is_tx && state_ff == srt_pkg::SRT_LS_WLMFC
				&& lmfc_boundary;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Test mode outputs

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_select     <= `SRT_RST_TEST;
			prbs_enable     <= 1'b0;
			link_data_off   <= 1'b0;
			alignment_sequence_length <= `SRT_RST_ILA_LEN;
		end else begin
			alignment_sequence_length <= ila_len_ff;
			if (!is_tx && (test_sel_ff == srt_pkg::SRT_TM_RPAT
				|| test_sel_ff == srt_pkg::SRT_TM_JSPAT))
				test_select <= srt_pkg::SRT_TM_NORMAL;
			else
				test_select <= test_sel_ff;
			prbs_enable   <= is_tx && test_sel_ff[`SRT_BIT_PRBS];
			link_data_off <= is_tx && test_sel_ff[`SRT_BIT_PRBS];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Misalignment counting per lane

	logic [2:0] mis_cnt_ff [`SRT_LANES];
	logic [7:0] mis_hit;

	genvar gi;
	generate
		for (gi = 0; gi < `SRT_LANES; gi++) begin : g_lane
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					mis_cnt_ff[gi] <= 3'h0;
				else if (lane_align_ok[gi])
					mis_cnt_ff[gi] <= 3'h0;
				else if (lane_misalign[gi]
					&& mis_cnt_ff[gi] != `SRT_MISALIGN_LIMIT)
					mis_cnt_ff[gi] <= mis_cnt_ff[gi] + 3'h1;
			end
			assign mis_hit[gi] = lane_misalign[gi]
				&& mis_cnt_ff[gi] == (`SRT_MISALIGN_LIMIT - 3'h1);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Error status word

	logic sys_mis;
	assign sys_mis = subclass1 && sys_evt && !lmfc_boundary;

	always_comb begin
		nxt_err = 32'h0000_0000;
		for (int i = 0; i < `SRT_LANES; i++) begin
			nxt_err[3*i+2] = err_kchar[i];
			nxt_err[3*i+1] = err_disp[i];
			nxt_err[3*i]   = err_nit[i];
		end
		nxt_err[`SRT_BIT_ALIGN_ALARM] = |mis_hit;
		nxt_err[`SRT_BIT_SYSREF_ALRM] = sys_mis;
		nxt_err[`SRT_BIT_OVF_ALARM]   = buffer_overflow;
		if (!lane_sync_done)
			nxt_err = 32'h0000_0000;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			err_ff <= 32'h0000_0000;
		else if (watchdog_clear)
			err_ff <= nxt_err;
		else if (acc && rd_err)
			err_ff <= nxt_err;
		else
			err_ff <= err_ff | nxt_err;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_sys_edge;
		sys_s2_ff && !sys_s3_ff;
	endsequence

	a_err_sticky: assert property (
		err_ff[0] && !(acc && rd_err) && !watchdog_clear |=> err_ff[0])
		else $error("error bit lost without read");

	a_read_clear: assert property (
		acc && rd_err && !watchdog_clear |=> err_ff == $past(nxt_err))
		else $error("read did not clear error word");

	a_evt_wins: assert property (
		acc && rd_err && err_nit[0] && lane_sync_done |=> err_ff[0])
		else $error("error lost in read cycle");

	a_rsvd_zero: assert property (
		err_ff[28:24] == 5'h00)
		else $error("reserved error bits set");

	a_no_sync_err: assert property (
		!lane_sync_done && !(acc && rd_err) && !watchdog_clear
		|=> err_ff == $past(err_ff))
		else $error("error recorded before sync");

	a_no_delay: assert property (
		s_sys_edge and sysref_ctl_ff[0] && dly_zero |=> realign_ff)
		else $error("SYSREF did not realign");

	a_first_only: assert property (
		s_sys_edge and seen_first_ff && !sysref_ctl_ff[0] && !dly_run_ff
		|=> !realign_ff)
		else $error("later SYSREF realigned");

	a_delay_max: assert property (
		sys_take && sysref_ctl_ff[11:8] == 4'hF |=> !realign_ff [*8] ##8
		realign_ff)
		else $error("SYSREF delay wrong");

	a_prbs_off: assert property (
		is_tx && test_sel_ff[4] |=> link_data_off && prbs_enable)
		else $error("PRBS did not disable link data");

	a_wait_sys: assert property (
		state_ff == srt_pkg::SRT_LS_WSYS && is_tx |=> send_k285)
		else $error("K28.5 not sent while waiting SYSREF");

	a_rx_hold: assert property (
		state_ff == srt_pkg::SRT_LS_WSYS && !is_tx |=> sync_hold)
		else $error("SYNC released while waiting SYSREF");

	a_ila_start: assert property (
		state_ff == srt_pkg::SRT_LS_WLMFC && lmfc_boundary && is_tx
		|=> start_ila)
		else $error("ILA did not start at boundary");

	a_sync_free: assert property (
		state_ff == srt_pkg::SRT_LS_ALIGN |=> !sync_hold && !send_k285)
		else $error("link not released after boundary");

	a_rx_codes: assert property (
		!is_tx && (test_sel_ff == 5'h05 || test_sel_ff == 5'h07)
		|=> test_select == 5'h00)
		else $error("transmit-only test code used on receive");

	a_align_alarm: assert property (
		lane_sync_done && (|mis_hit) |=> err_ff[`SRT_BIT_ALIGN_ALARM])
		else $error("alignment alarm not set");

	a_sysref_alarm: assert property (
		sys_mis && lane_sync_done |=> err_ff[`SRT_BIT_SYSREF_ALRM])
		else $error("SYSREF alarm not set");

	a_ovf_alarm: assert property (
		buffer_overflow && lane_sync_done |=> err_ff[`SRT_BIT_OVF_ALARM])
		else $error("overflow alarm not set");

	a_wdog_clear: assert property (
		watchdog_clear |=> err_ff == $past(nxt_err))
		else $error("watchdog did not clear error word");

endmodule

// ### tb/srt_link_model.sv
// Purpose: Converter-side event source for the register bank
// Assumes: Driven from the bench, changes just after rising pclk
// Notes:   Events are one-cycle pulses, SYSREF is a level
`timescale 1ns/1ps

module srt_link_model (
	// Clock
	input  wire logic       pclk,
	// Link events
	output logic            sysref_in,
	output logic            resync_req,
	output logic            lmfc_boundary,
	output logic            lane_sync_done,
	output logic            buffer_overflow,
	output logic      [7:0] lane_misalign,
	output logic      [7:0] err_kchar,
	output logic      [7:0] err_disp,
	output logic      [7:0] err_nit
);
	initial begin
		{sysref_in, resync_req, lmfc_boundary, lane_sync_done} = 4'h0;
		buffer_overflow = 1'b0;
		{lane_misalign, err_kchar, err_disp, err_nit} = 32'h0;
	end
	////////////////////////////////////////////////////////////////////////
	// Level controls
	task sysref(input logic v);
		sysref_in <= v;
	endtask
	task sync(input logic v);
		lane_sync_done <= v;
	endtask
	////////////////////////////////////////////////////////////////////////
	// One-cycle pulse, then one idle cycle
	task strobe(input int k, input logic [7:0] m);
		case (k)
			0: resync_req <= 1'b1;
			1: lmfc_boundary <= 1'b1;
			2: buffer_overflow <= 1'b1;
			3: lane_misalign <= m;
			4: err_kchar <= m;
			5: err_disp <= m;
			default: err_nit <= m;
		endcase
		@(posedge pclk);
		{resync_req, lmfc_boundary, buffer_overflow} <= 3'h0;
		{lane_misalign, err_kchar, err_disp, err_nit} <= 32'h0;
		@(posedge pclk);
	endtask
endmodule

// ### tb/sysref_testmode_error_regs_bench.sv
// Purpose: Self-checking bench for the register bank
// Assumes: APB master on pclk, link events from srt_link_model
// Notes:   Core starts as transmitter in subclass 0, runs as receiver after the second reset
`include "srt_defs.svh"
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end

module sysref_testmode_error_regs_bench;
	logic        pclk, presetn, psel, penable, pwrite, err_seen;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, lmfc_realign, send_k285, start_ila;
	logic        sync_hold, prbs_enable, link_data_off, sysref_in;
	logic        is_tx, subclass1, watchdog_clear;
	logic [7:0]  lane_align_ok;
	logic        resync_req, lmfc_boundary, lane_sync_done, buffer_overflow;
	logic [7:0]  alignment_sequence_length, lane_misalign, err_kchar, err_disp, err_nit;
	logic [4:0]  test_select;
	logic [4:0]  codes [7] = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h07, 5'h10, 5'h00};
	logic [7:0]  lens [2] = '{8'hFF, 8'h03};
	int          n_fail, checks_done, cyc, l0, l15;

	srt_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.is_tx(is_tx), .subclass1(subclass1),
		.sysref_in(sysref_in), .resync_req(resync_req),
		.lmfc_boundary(lmfc_boundary), .lane_sync_done(lane_sync_done),
		.watchdog_clear(watchdog_clear), .lane_misalign(lane_misalign),
		.lane_align_ok(lane_align_ok), .buffer_overflow(buffer_overflow),
		.err_kchar(err_kchar), .err_disp(err_disp), .err_nit(err_nit),
		.lmfc_realign(lmfc_realign), .send_k285(send_k285),
		.start_ila(start_ila), .sync_hold(sync_hold),
		.alignment_sequence_length(alignment_sequence_length), .test_select(test_select),
		.prbs_enable(prbs_enable), .link_data_off(link_data_off));
	srt_link_model i_link (.pclk(pclk), .sysref_in(sysref_in),
		.resync_req(resync_req), .lmfc_boundary(lmfc_boundary),
		.lane_sync_done(lane_sync_done), .buffer_overflow(buffer_overflow),
		.lane_misalign(lane_misalign), .err_kchar(err_kchar),
		.err_disp(err_disp), .err_nit(err_nit));
	////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 6000) begin
			n_fail++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task conclude();
		if (n_fail == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask
	// Cycles from SYSREF rise to realign pulse, 40 if none
	task lat(output int c);
		i_link.sysref(1'b1);
		c = 0;
		do begin
			@(posedge pclk);
			c++;
		end while (lmfc_realign !== 1'b1 && c < 40);
		i_link.sysref(1'b0);
		repeat (4) @(posedge pclk);
	endtask
	task resync(input logic need);
		int seen;
		i_link.strobe(0, 8'h00);
		repeat (2) @(posedge pclk);
		`CHK(send_k285, is_tx)
		`CHK(sync_hold, !is_tx)
		if (need) begin
			i_link.strobe(1, 8'h00);
			`CHK(send_k285, is_tx)
			`CHK(sync_hold, !is_tx)
			lat(seen);
		end
		seen = 0;
		fork
			i_link.strobe(1, 8'h00);
			repeat (5) begin
				@(posedge pclk);
				if (start_ila === 1'b1)
					seen++;
			end
		join
		`CHK(seen, is_tx)
		`CHK(send_k285 | sync_hold, 1'b0)
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{psel, penable, pwrite} = 3'h0;
		{is_tx, subclass1, watchdog_clear} = 3'h4;
		lane_align_ok = 8'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		presetn = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(`SRT_OFS_SYSREF, 32'h0000_00FE);
		rchk(`SRT_OFS_ILA_LEN, 32'h0000_0003);
		rchk(`SRT_OFS_TEST, 32'h0000_0000);
		rchk(`SRT_OFS_ERR, 32'h0000_0000);
		rchk(12'h020, 32'h0000_0000);
		`CHK(err_seen, 1'b1)
		lat(l0);
		`CHK(l0 < 40, 1'b1)
		lat(l15);
		`CHK(l15, 40)
		apb(1'b1, `SRT_OFS_SYSREF, 32'h0000_0001);
		lat(l0);
		apb(1'b1, `SRT_OFS_SYSREF, 32'h0000_0F01);
		rchk(`SRT_OFS_SYSREF, 32'h0000_0FFF);
		lat(l15);
		`CHK(l15 - l0, 15)
		apb(1'b1, `SRT_OFS_SYSREF, 32'h0001_0001);
		resync(1'b1);
		apb(1'b1, `SRT_OFS_SYSREF, 32'h0000_0001);
		resync(1'b0);
		foreach (lens[i]) begin
			apb(1'b1, `SRT_OFS_ILA_LEN, {24'h0, lens[i]});
			rchk(`SRT_OFS_ILA_LEN, {24'h0, lens[i]});
			`CHK(alignment_sequence_length, lens[i])
		end
		foreach (codes[i]) begin
			apb(1'b1, `SRT_OFS_TEST, {27'h0, codes[i]});
			rchk(`SRT_OFS_TEST, {27'h0, codes[i]});
			`CHK(test_select, codes[i])
			`CHK(prbs_enable, codes[i][4])
			`CHK(link_data_off, codes[i][4])
		end
		i_link.strobe(4, 8'hFF);
		rchk(`SRT_OFS_ERR, 32'h0000_0000);
		i_link.sync(1'b1);
		i_link.strobe(4, 8'h80);
		i_link.strobe(5, 8'h01);
		i_link.strobe(6, 8'h08);
		i_link.strobe(2, 8'h00);
		rchk(`SRT_OFS_ERR, 32'h2080_0202);
		rchk(`SRT_OFS_ERR, 32'h0000_0000);
		fork
			rchk(`SRT_OFS_ERR, 32'h0000_0000);
			begin
				@(posedge pclk);
				i_link.strobe(6, 8'h01);
			end
		join
		rchk(`SRT_OFS_ERR, 32'h0000_0001);
		i_link.strobe(4, 8'h01);
		watchdog_clear <= 1'b1;
		@(posedge pclk);
		watchdog_clear <= 1'b0;
		rchk(`SRT_OFS_ERR, 32'h0000_0000);
		subclass1 <= 1'b1;
		lat(l0);
		subclass1 <= 1'b0;
		rchk(`SRT_OFS_ERR, 32'h4000_0000);
		repeat (6) i_link.strobe(3, 8'h04);
		lane_align_ok <= 8'h04;
		@(posedge pclk);
		lane_align_ok <= 8'h00;
		repeat (6) i_link.strobe(3, 8'h04);
		rchk(`SRT_OFS_ERR, 32'h0000_0000);
		i_link.strobe(3, 8'h04);
		rchk(`SRT_OFS_ERR, 32'h8000_0000);
		i_link.strobe(5, 8'h10);
		presetn <= 1'b0;
		is_tx <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(`SRT_OFS_ERR, 32'h0000_0000);
		apb(1'b1, `SRT_OFS_SYSREF, 32'h0001_0001);
		resync(1'b1);
		apb(1'b1, `SRT_OFS_SYSREF, 32'h0000_0001);
		resync(1'b0);
		apb(1'b1, `SRT_OFS_TEST, 32'h0000_0005);
		rchk(`SRT_OFS_TEST, 32'h0000_0005);
		`CHK(test_select, 5'h00)
		apb(1'b1, `SRT_OFS_TEST, 32'h0000_0010);
		rchk(`SRT_OFS_TEST, 32'h0000_0010);
		`CHK(prbs_enable | link_data_off, 1'b0)
		conclude();
	end
endmodule
